// ===== hw/usfl_top.sv
// Status-flag logic of an asynchronous serial transceiver, with its
// receive and transmit data buffers, behind an AXI4-Lite slave.
// Assumes the shifters run on aclk and report frames as one-cycle pulses.
`timescale 1ns/100ps
module usfl_top #(
  parameter int ADDR_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Receive shifter side
  input wire usfl_pkg::usfl_rx_evt_t rx_evt,
  output logic rx_enable,
  // Transmit shifter side
  input wire logic tx_busy,
  input wire logic tx_frame_done,
  output logic tx_load,
  output logic [7:0] tx_data,
  // Interrupt request pulses
  output logic rx_interrupt_request,
  output logic tx_interrupt_request
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  // Write channel state
  logic awready_r;
  logic aw_hold_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic wready_r;
  logic w_hold_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  // Read channel state
  logic arready_r;
  logic ar_hold_r;
  logic [ADDR_W-1:0] araddr_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  // Bus strobes
  logic wr_fire;      // Both halves of a write are held
  logic rd_fire;      // A read address is held
  logic wr_mapped;    // Write address decodes
  logic rd_mapped;    // Read address decodes
  logic wr_tx;        // Write to tx_data_buffer
  logic wr_ctrl;      // Write to control
  logic rd_status;    // Read of serial_status_register
  logic rd_rxbuf;     // Read of rx_data_buffer
  // Control and buffers
  logic [1:0] ctrl_r;       // Receive and transmit enables
  logic [7:0] rx_data_buffer_r;
  logic [7:0] tx_data_buffer_r;
  // Flag wiring
  logic parity_error_flag;
  logic framing_error_flag;
  logic oerr_flag;
  logic rbfl_flag;
  logic tbep_flag;
  logic tbep_armed;
  logic tend_r;
  // Frame events
  logic rx_live;      // Frame may be taken at all
  logic rx_accept;    // Frame goes into the buffer
  logic rx_overrun;   // Frame arrives while buffer still full
  logic tx_accept;    // Armed write fills the transmit buffer
  logic load_go;      // Buffer moves into the transmit shifter
  // Registered outputs
  logic rx_enable_r;
  logic tx_load_r;
  logic [7:0] tx_data_r;
  logic rx_irq_r;
  logic tx_irq_r;
  logic [31:0] status_word;

  ////////////////////////////////////////////////////////////////////////
  // Write address channel: one write at a time, ready drops once taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      aw_hold_r <= 1'b0;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && awready_r) begin
      awready_r <= 1'b0;
      aw_hold_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (bvalid_r && s_axi_bready) begin
      awready_r <= 1'b1;
      aw_hold_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write data channel: taken independently of the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b1;
      w_hold_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && wready_r) begin
      wready_r <= 1'b0;
      w_hold_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (bvalid_r && s_axi_bready) begin
      wready_r <= 1'b1;
      w_hold_r <= 1'b0;
    end
  end

  // Write decode; only byte lane 0 carries data
  assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_mapped = (awaddr_r == usfl_pkg::OFF_STATUS) || (awaddr_r == usfl_pkg::OFF_RXBUF) ||
                     (awaddr_r == usfl_pkg::OFF_TXBUF) || (awaddr_r == usfl_pkg::OFF_CTRL);
  assign wr_tx = wr_fire && (awaddr_r == usfl_pkg::OFF_TXBUF) && wstrb_r[0];
  assign wr_ctrl = wr_fire && (awaddr_r == usfl_pkg::OFF_CTRL) && wstrb_r[0];

  ////////////////////////////////////////////////////////////////////////
  // Write response: one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= usfl_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      // Read-only registers ignore writes silently
      bresp_r <= wr_mapped ? usfl_pkg::RESP_OKAY : usfl_pkg::RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      ar_hold_r <= 1'b0;
      araddr_r <= '0;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      ar_hold_r <= 1'b1;
      araddr_r <= s_axi_araddr;
    end else if (rd_fire) begin
      ar_hold_r <= 1'b0;
    end else if (rvalid_r && s_axi_rready) begin
      arready_r <= 1'b1;
    end
  end

  // Read decode; side effects happen once, at rd_fire
  assign rd_fire = ar_hold_r && !rvalid_r;
  assign rd_mapped = (araddr_r == usfl_pkg::OFF_STATUS) || (araddr_r == usfl_pkg::OFF_RXBUF) ||
                     (araddr_r == usfl_pkg::OFF_TXBUF) || (araddr_r == usfl_pkg::OFF_CTRL);
  assign rd_status = rd_fire && (araddr_r == usfl_pkg::OFF_STATUS);
  assign rd_rxbuf = rd_fire && (araddr_r == usfl_pkg::OFF_RXBUF);

  // Status word; upper bits read as zero
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[usfl_pkg::BIT_PARITY] = parity_error_flag;
    status_word[usfl_pkg::BIT_FRAMING] = framing_error_flag;
    status_word[usfl_pkg::BIT_OERR] = oerr_flag;
    status_word[usfl_pkg::BIT_RBFL] = rbfl_flag;
    status_word[usfl_pkg::BIT_TBEP] = tbep_flag;
    status_word[usfl_pkg::BIT_TEND] = tend_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data: captured at rd_fire, so the flags shown are those armed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= usfl_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rresp_r <= rd_mapped ? usfl_pkg::RESP_OKAY : usfl_pkg::RESP_SLVERR;
      case (araddr_r)
        usfl_pkg::OFF_STATUS: begin
          rdata_r <= status_word;
        end
        usfl_pkg::OFF_RXBUF: begin
          rdata_r <= {24'h00_0000, rx_data_buffer_r};
        end
        usfl_pkg::OFF_TXBUF: begin
          rdata_r <= {24'h00_0000, tx_data_buffer_r};
        end
        usfl_pkg::OFF_CTRL: begin
          rdata_r <= {30'h0000_0000, ctrl_r};
        end
        default: begin
          // Unmapped reads return zero with an error
          rdata_r <= 32'h0000_0000;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register: enables steer both frame paths
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= usfl_pkg::RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_r <= wdata_r[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive frame classification
  // Frames are ignored while disabled or while an overrun is pending
  assign rx_live = rx_evt.done && ctrl_r[usfl_pkg::BIT_RX_EN] && !oerr_flag;
  assign rx_accept = rx_live && !rbfl_flag;
  assign rx_overrun = rx_live && rbfl_flag;

  // Receive buffer: an overrun frame never reaches it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data_buffer_r <= usfl_pkg::RST_DATA;
    end else if (rx_accept) begin
      rx_data_buffer_r <= rx_evt.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive flags; each clears only if armed by an earlier status read
  usfl_flag #(.RST_VAL(usfl_pkg::RST_PARITY)) u_parity (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(rx_accept && rx_evt.parity_bad),
    .arm(rd_status),
    .clr(rd_rxbuf),
    .flag(parity_error_flag),
    .armed()
  );

  usfl_flag #(.RST_VAL(usfl_pkg::RST_FRAMING)) u_framing (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(rx_accept && !rx_evt.stop_bit),
    .arm(rd_status),
    .clr(rd_rxbuf),
    .flag(framing_error_flag),
    .armed()
  );

  // A set after the status read is not armed and survives the access
  usfl_flag #(.RST_VAL(usfl_pkg::RST_OERR)) u_oerr (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(rx_overrun),
    .arm(rd_status),
    .clr(rd_rxbuf),
    .flag(oerr_flag),
    .armed()
  );

  usfl_flag #(.RST_VAL(usfl_pkg::RST_RBFL)) u_rbfl (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(rx_accept),
    .arm(rd_status),
    .clr(rd_rxbuf),
    .flag(rbfl_flag),
    .armed()
  );

  ////////////////////////////////////////////////////////////////////////
  // Transmit side
  // Only a write armed by a status read that saw the buffer empty counts
  assign tx_accept = wr_tx && tbep_armed;
  // Buffer moves to the shifter when full, enabled and the shifter idles;
  // tx_load_r blocks a second load before tx_busy rises
  assign load_go = !tbep_flag && ctrl_r[usfl_pkg::BIT_TX_EN] && !tx_busy && !tx_load_r;

  usfl_flag #(.RST_VAL(usfl_pkg::RST_TBEP)) u_tbep (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(load_go),
    .arm(rd_status),
    .clr(wr_tx),
    .flag(tbep_flag),
    .armed(tbep_armed)
  );

  // Transmit buffer holds the byte until the shifter takes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_data_buffer_r <= usfl_pkg::RST_DATA;
    end else if (tx_accept) begin
      tx_data_buffer_r <= wdata_r[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit end: set when a frame ends with nothing queued
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tend_r <= usfl_pkg::RST_TEND;
    end else if (tx_frame_done && tbep_flag) begin
      tend_r <= 1'b1;
    end else if (load_go) begin
      tend_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shifter load strobe and data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_load_r <= 1'b0;
      tx_data_r <= usfl_pkg::RST_DATA;
    end else begin
      tx_load_r <= load_go;
      if (load_go) begin
        tx_data_r <= tx_data_buffer_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt request pulses and receive enable
  // rx_enable lags the flag by one cycle; internal gating does not
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_irq_r <= 1'b0;
      tx_irq_r <= 1'b0;
      rx_enable_r <= 1'b0;
    end else begin
      rx_irq_r <= rx_accept;
      tx_irq_r <= load_go;
      rx_enable_r <= ctrl_r[usfl_pkg::BIT_RX_EN] && !oerr_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output drive, all from flip-flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign rx_enable = rx_enable_r;
  assign tx_load = tx_load_r;
  assign tx_data = tx_data_r;
  assign rx_interrupt_request = rx_irq_r;
  assign tx_interrupt_request = tx_irq_r;

endmodule : usfl_top

// ===== hw/usfl_pkg.sv
// Constants and carrier types shared by the serial status-flag logic.
// Assumes a 32-bit AXI4-Lite register bus and one 250 MHz system clock.
package usfl_pkg;

  // Register byte offsets on the 4-bit local address
  localparam logic [3:0] OFF_STATUS = 4'h0;
  localparam logic [3:0] OFF_RXBUF = 4'h4;
  localparam logic [3:0] OFF_TXBUF = 4'h8;
  localparam logic [3:0] OFF_CTRL = 4'hC;

  // Bit positions in serial_status_register
  localparam int BIT_PARITY = 0;
  localparam int BIT_FRAMING = 1;
  localparam int BIT_OERR = 2;
  localparam int BIT_RBFL = 3;
  localparam int BIT_TBEP = 4;
  localparam int BIT_TEND = 5;

  // Bit positions in the control register
  localparam int BIT_RX_EN = 0;
  localparam int BIT_TX_EN = 1;

  // Values after reset
  localparam logic RST_PARITY = 1'b0;
  localparam logic RST_FRAMING = 1'b0;
  localparam logic RST_OERR = 1'b0;
  localparam logic RST_RBFL = 1'b0;
  localparam logic RST_TBEP = 1'b1;
  localparam logic RST_TEND = 1'b1;
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [7:0] RST_DATA = 8'h00;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One received frame as reported by the receive shifter
  typedef struct packed {
    logic done;        // One-cycle pulse: all bits of a frame are in
    logic stop_bit;    // Value sampled in the stop bit position
    logic parity_bad;  // Computed parity disagrees with received parity
    logic [7:0] data;  // Extracted data bits
  } usfl_rx_evt_t;

endpackage : usfl_pkg

// ===== hw/usfl_flag.sv
// One status flag with the two-step read-then-access clearing sequence.
// Assumes set, arm and clr are one-cycle strobes on aclk.
`timescale 1ns/100ps
module usfl_flag #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic set,    // Hardware event
  input wire logic arm,    // Status register read
  input wire logic clr,    // Buffer access
  output logic flag,
  output logic armed
);

  logic flag_r;   // Visible flag
  logic armed_r;  // Flag was seen set by a status read

  ////////////////////////////////////////////////////////////////////////
  // Flag: a set in the same cycle as a clear wins, so no event is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= RST_VAL;
    end else if (set) begin
      flag_r <= 1'b1;
    end else if (clr && armed_r) begin
      flag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Arm: captures the flag as software saw it; a later set is not armed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_r <= 1'b0;
    end else if (arm) begin
      armed_r <= flag_r;
    end else if (clr) begin
      armed_r <= 1'b0;
    end
  end

  assign flag = flag_r;
  assign armed = armed_r;

endmodule : usfl_flag

// ===== tb/usfl_far.sv
// Far-end serial shifters: received frames arrive as one-cycle reports,
// and each loaded byte keeps the transmit shifter busy for tx_len cycles.
// Assumes it shares aclk with the status-flag logic.
`timescale 1ns/100ps
module usfl_far (
  input wire logic aclk,
  input wire logic tx_load,
  input wire logic [7:0] tx_data,
  output usfl_pkg::usfl_rx_evt_t rx_evt,
  output logic tx_busy,
  output logic tx_frame_done
);
  int tx_len = 6; // Frame length in cycles; the bench sets it to 40, then 2
  int tx_cnt = 0; // Cycles left in the frame on the wire
  logic [7:0] txq[$]; // Every byte the shifter took
  // Idle shifters at time zero
  initial begin
    rx_evt <= '0;
    tx_busy <= 1'h0;
    tx_frame_done <= 1'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One frame report; fields are scrambled after it, as nobody holds them
  task automatic send(input logic [7:0] d, input logic pb, input logic stp);
    rx_evt <= '{done: 1'h1, stop_bit: stp, parity_bad: pb, data: d};
    @(posedge aclk);
    rx_evt <= '{done: 1'h0, stop_bit: ~stp, parity_bad: ~pb, data: ~d};
  endtask : send
  ////////////////////////////////////////////////////////////////////////////
  // Shift out a loaded byte, then pulse the end of frame
  always @(posedge aclk) begin
    // End-of-frame pulse in the cycle the last bit leaves
    tx_frame_done <= !tx_load && tx_cnt == 1;
    if (tx_load) begin
      txq.push_back(tx_data);
      tx_busy <= 1'h1;
      tx_cnt <= tx_len;
    end else if (tx_cnt > 1) begin
      tx_cnt <= tx_cnt - 1;
    end else if (tx_cnt == 1) begin
      tx_cnt <= 0;
      tx_busy <= 1'h0;
    end
  end
endmodule : usfl_far

// ===== tb/usfl_assertions.sv
// Checker for the serial status-flag logic: bus timing, shifter strobes
// and interrupt pulses as seen at the top-level ports.
// Assumes one clock aclk and the synchronous active-low reset aresetn.
`timescale 1ns/100ps
module usfl_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire usfl_pkg::usfl_rx_evt_t rx_evt,
  input wire logic tx_busy,
  input wire logic tx_load,
  input wire logic [7:0] tx_data,
  input wire logic rx_interrupt_request,
  input wire logic tx_interrupt_request
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  // Shifter strobes and interrupt pulses
  a_txirq_with_load: assert property (tx_interrupt_request == tx_load)
    else $error("tx interrupt request and tx load differ");
  a_load_one_cycle: assert property (tx_load |=> !tx_load && $stable(tx_data))
    else $error("tx load longer than one cycle or tx data moved");
  a_load_when_idle: assert property (tx_load |-> !$past(tx_busy))
    else $error("tx load while the shifter was busy");
  a_rxirq_after_frame: assert property (rx_interrupt_request |-> $past(rx_evt.done) && !$past(rx_interrupt_request))
    else $error("rx interrupt request without a frame just before");
  ////////////////////////////////////////////////////////////////////////////
  // Register bus: answers stand until taken, fixed answer delay
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed before bready");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed before rready");
  a_read_delay: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("read answer not two cycles after the address");
  a_write_delay: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two cycles after address and data");
  a_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp == usfl_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read returned nonzero data");
  a_one_at_a_time: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while a read answer is open");
  // Main scenarios reached
  c_tx_load: cover property (tx_load);
  c_rx_irq: cover property (rx_interrupt_request);
  c_refused: cover property (s_axi_rvalid && s_axi_rresp == usfl_pkg::RESP_SLVERR);
endmodule : usfl_assertions

bind usfl_top usfl_assertions i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .rx_evt, .tx_busy, .tx_load, .tx_data, .rx_interrupt_request,
  .tx_interrupt_request);

// ===== tb/uart_status_flag_logic_bench.sv
// Self-checking bench: AXI4-Lite master, a flag model kept in bits and
// queues, and the far-end shifter model.
// Assumes usfl_pkg, usfl_top, usfl_far and the bound checker are compiled.
`timescale 1ns/100ps
module uart_status_flag_logic_bench;
  logic aclk, aresetn = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  usfl_pkg::usfl_rx_evt_t rx_evt;
  logic rx_enable, tx_busy, tx_frame_done, tx_load, rx_interrupt_request, tx_interrupt_request;
  logic [7:0] tx_data;
  int n_mismatch = 0, check_count = 0, seed = 78, n_irq = 0, x_irq = 0, n_tirq = 0;
  logic [5:0] m_flag = 6'h30; // Model, bit 5 down: end, empty, full, overrun, framing, parity
  logic [5:0] m_arm = 6'h00; // Flags seen set by the last status read
  logic [7:0] m_buf = 8'h00; // Model receive buffer
  logic m_rx_on = 1'h0; // Receive enable written so far
  logic [7:0] x_tx[$]; // Bytes the shifter should take

  usfl_top #(.ADDR_W(4)) i_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .rx_evt, .rx_enable, .tx_busy, .tx_frame_done, .tx_load, .tx_data,
    .rx_interrupt_request, .tx_interrupt_request);
  usfl_far i_far (.aclk, .tx_load, .tx_data, .rx_evt, .tx_busy, .tx_frame_done);

  // 250 MHz clock
  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end
  // Count interrupt pulses of both kinds
  always @(posedge aclk) if (rx_interrupt_request === 1'h1) n_irq++;
  always @(posedge aclk) if (tx_interrupt_request === 1'h1) n_tirq++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // A wait that ran out is a failure
  task automatic hang;
    n_mismatch++;
    complete_run();
  endtask : hang
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk_word({30'h0, got}, {30'h0, exp});
  endtask : chk_resp
  ////////////////////////////////////////////////////////////////////////////
  // Bus cycles; the answer is taken after a random stall
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n, st;
    logic aw_d, w_d;
    {aw_d, w_d} = 2'h0;
    st = $unsigned($random(seed)) % 4;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(aw_d && w_d)) begin
      @(posedge aclk);
      aw_d = aw_d | s_axi_awready;
      w_d = w_d | s_axi_wready;
      s_axi_awvalid <= ~aw_d;
      s_axi_wvalid <= ~w_d;
      if (++n > 50) hang();
    end
    repeat (st) @(posedge aclk);
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (++n > 100) hang();
    end while (s_axi_bvalid !== 1'h1);
    chk_resp(s_axi_bresp, er);
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n, st;
    st = $unsigned($random(seed)) % 4;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (++n > 50) hang();
    end while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    repeat (st) @(posedge aclk);
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (++n > 100) hang();
    end while (s_axi_rvalid !== 1'h1);
    chk_word(s_axi_rdata, ed);
    chk_resp(s_axi_rresp, er);
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask : axi_rd
  ////////////////////////////////////////////////////////////////////////////
  // Model-tracking accesses
  task automatic rd_status;
    axi_rd(usfl_pkg::OFF_STATUS, {26'h0, m_flag}, usfl_pkg::RESP_OKAY);
    m_arm = m_flag;
  endtask : rd_status
  task automatic rd_rxbuf;
    axi_rd(usfl_pkg::OFF_RXBUF, {24'h0, m_buf}, usfl_pkg::RESP_OKAY);
    m_flag[3:0] = m_flag[3:0] & ~m_arm[3:0];
    m_arm[3:0] = 4'h0;
  endtask : rd_rxbuf
  task automatic wr_tx(input logic [7:0] d);
    axi_wr(usfl_pkg::OFF_TXBUF, {24'h0, d}, usfl_pkg::RESP_OKAY);
    // Only a write after a status read that saw empty is taken
    if (m_arm[4]) begin
      m_flag[4] = 1'h0;
      x_tx.push_back(d);
    end
    m_arm[4] = 1'h0;
  endtask : wr_tx
  // One frame, random data; flags settle and the pulse lands in two cycles
  task automatic frame(input logic pb, input logic stp);
    logic [7:0] d;
    d = 8'($random(seed));
    i_far.send(d, pb, stp);
    if (m_rx_on && !m_flag[2]) begin
      if (m_flag[3]) m_flag[2] = 1'h1;
      else begin
        m_buf = d;
        m_flag[3] = 1'h1;
        m_flag[0] = m_flag[0] | pb;
        m_flag[1] = m_flag[1] | ~stp;
        x_irq++;
      end
    end
    repeat (2) @(posedge aclk);
  endtask : frame
  // Wait until the shifter took every byte expected
  task automatic wait_load;
    int n;
    while (i_far.txq.size() < x_tx.size()) begin
      @(posedge aclk);
      if (++n > 200) hang();
    end
    chk_word(i_far.txq[$], {24'h0, x_tx[$]});
    m_flag[5:4] = 2'h1;
  endtask : wait_load
  task automatic wait_done;
    int n;
    do begin
      @(posedge aclk);
      if (++n > 200) hang();
    end while (tx_frame_done !== 1'h1);
    @(posedge aclk);
    m_flag[5] = m_flag[5] | m_flag[4];
  endtask : wait_done
  ////////////////////////////////////////////////////////////////////////////
  initial begin : main
    logic pb, stp;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd_status();
    axi_rd(usfl_pkg::OFF_CTRL, 32'h0, usfl_pkg::RESP_OKAY);
    axi_rd(4'h2, 32'h0, usfl_pkg::RESP_SLVERR);
    axi_wr(4'h6, 32'h5, usfl_pkg::RESP_SLVERR);
    axi_wr(usfl_pkg::OFF_STATUS, 32'h0, usfl_pkg::RESP_OKAY);
    frame(1'h1, 1'h0);
    rd_status();
    $display("test reset and map done");
    axi_wr(usfl_pkg::OFF_CTRL, 32'h3, usfl_pkg::RESP_OKAY);
    m_rx_on = 1'h1;
    // A write without byte lane 0 must leave control alone
    s_axi_wstrb <= 4'hE;
    axi_wr(usfl_pkg::OFF_CTRL, 32'h0, usfl_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axi_rd(usfl_pkg::OFF_CTRL, 32'h3, usfl_pkg::RESP_OKAY);
    frame(1'h1, 1'h0);
    rd_rxbuf();
    rd_status();
    rd_rxbuf();
    rd_status();
    $display("test error flags done");
    frame(1'h0, 1'h1);
    frame(1'h1, 1'h0);
    chk_word({31'h0, rx_enable}, 32'h0);
    frame(1'h0, 1'h1);
    rd_status();
    rd_rxbuf();
    chk_word({31'h0, rx_enable}, 32'h1);
    frame(1'h0, 1'h1);
    rd_status();
    frame(1'h0, 1'h1);
    rd_rxbuf();
    rd_status();
    rd_rxbuf();
    $display("test overrun done");
    for (int i = 0; i < 10; i++) begin
      {pb, stp} = 2'($random(seed));
      frame(pb, stp);
      if (pb | stp) begin
        rd_status();
        rd_rxbuf();
      end
    end
    chk_word(n_irq, x_irq);
    $display("test random frames done");
    i_far.tx_len = 40;
    rd_status();
    wr_tx(8'hA5);
    wr_tx(8'h3C);
    wait_load();
    rd_status();
    wr_tx(8'($random(seed)));
    rd_status();
    wait_load();
    rd_status();
    wait_done();
    rd_status();
    i_far.tx_len = 2;
    wr_tx(8'($random(seed)));
    wait_load();
    repeat (6) @(posedge aclk);
    m_flag[5] = 1'h1;
    rd_status();
    chk_word(i_far.txq.size(), x_tx.size());
    chk_word(n_tirq, x_tx.size());
    $display("test transmit done");
    complete_run();
  end
endmodule : uart_status_flag_logic_bench
